// *** hdl/cms_regs.svh ***
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH
// bit positions inside the two special registers
`define CMS_MASK_BIT 0
`define CMS_SPSEL_BIT 1
// special register selector on the read/write instruction port
`define CMS_SEL_MASK 1'b0
`define CMS_SEL_CTRL 1'b1
// reset values
`define CMS_MASK_RST 1'b0
`define CMS_SPSEL_RST 1'b0
// transfer size codes
`define CMS_SIZE_BYTE 2'h0
`define CMS_SIZE_HALF 2'h1
`define CMS_SIZE_WORD 2'h2
// posted write classes
`define CMS_CLS_NORMAL 2'h0
`define CMS_CLS_DEV_NS 2'h1
`define CMS_CLS_DEV_SH 2'h2
// memory map, top address nibble where each region starts
`define CMS_NIB_PERIPH 4'h4
`define CMS_NIB_EXTRAM 4'h6
`define CMS_NIB_EXTDEV 4'ha
`define CMS_NIB_SYSTEM 4'he
// private peripheral bus page, address bits 31:20
`define CMS_PPB_PAGE 12'he00
`endif

// *** hdl/cms_pkg.sv ***
package cms_pkg;
    // memory type of a region
    typedef enum logic [1:0] {cms_normal, cms_device, cms_strong} cms_mem_type_t;
    // access sequencer states
    typedef enum logic [1:0] {st_idle, st_order, st_bus} cms_state_t;
endpackage

// *** hdl/cms_region_decode.sv ***
`timescale 1ns/100ps
`include "cms_regs.svh"
// fixed, non-relocatable map over the whole 4GB space
module cms_region_decode (
    input wire logic [31:0] addr,
    output wire cms_pkg::cms_mem_type_t mem_type,
    output wire logic xn,
    output wire logic private_peripheral_bus
);
    wire [3:0] nib = addr[31:28]; // region index
    // code, sram and external ram hold programs
    wire is_normal = (nib < `CMS_NIB_PERIPH) || (nib >= `CMS_NIB_EXTRAM && nib < `CMS_NIB_EXTDEV);
    // private peripheral bus is strongly ordered
    assign private_peripheral_bus = (addr[31:20] == `CMS_PPB_PAGE); // R12
    assign mem_type = private_peripheral_bus ? cms_pkg::cms_strong :
                      (is_normal ? cms_pkg::cms_normal : cms_pkg::cms_device); // R12
    // every device and strongly ordered region is execute never
    assign xn = !is_normal; // R17
endmodule

// *** hdl/cms_lane_steer.sv ***
`timescale 1ns/100ps
`include "cms_regs.svh"
// little-endian byte lane steering for word, halfword and byte
module cms_lane_steer (
    input wire logic [1:0] addr_lo,
    input wire logic [1:0] size,
    input wire logic [31:0] wdata,
    input wire logic [31:0] bus_rdata,
    output wire logic [3:0] be,
    output wire logic [31:0] lane_wdata,
    output wire logic [31:0] rdata,
    output wire logic misaligned
);
    wire is_byte = (size == `CMS_SIZE_BYTE); // 8-bit
    wire is_half = (size == `CMS_SIZE_HALF); // 16-bit
    wire is_word = (size == `CMS_SIZE_WORD); // 32-bit
    // lowest address holds the least significant byte
    wire [31:0] shifted = bus_rdata >> {addr_lo, 3'h0}; // R11
    // natural alignment only; an unknown size code is treated as misaligned
    assign misaligned = is_half ? addr_lo[0] : (is_word ? |addr_lo : !is_byte); // R10
    assign be = is_byte ? (4'h1 << addr_lo) : (is_half ? (4'h3 << addr_lo) : 4'hf); // R10 R11
    // replicate narrow data onto every lane it may land on
    assign lane_wdata = is_byte ? {4{wdata[7:0]}} : (is_half ? {2{wdata[15:0]}} : wdata); // R11
    // zero-extended read data
    assign rdata = is_byte ? {24'h0, shifted[7:0]} :
                   (is_half ? {16'h0, shifted[15:0]} : bus_rdata); // R11
endmodule

// *** hdl/cms_core_ctrl.sv ***
`timescale 1ns/100ps
`include "cms_regs.svh"
// Operation
// R1: mask bit blocks configurable priority exceptions
// R2: mask changed by special writes and cps
// R3: control bit 1 selects main or process stack
// R4: handler mode: select reads zero, writes ignored
// R5: handler mode always uses main stack
// R6: exception entry and return update control
// R7: thread mode defaults to main stack
// R8: new stack used after sync barrier
// R9: every exception except reset runs in handler
// R10: word, halfword and byte transfers supported
// R11: all accesses are little-endian
// R12: fixed 4GB map with typed regions
// R13: normal accesses may pass pending writes
// R14: device keeps order among device accesses
// R15: strongly ordered keeps order against everything
// R16: device writes may post, strong never
// R17: fetch from execute-never region raises fatal fault
// R18: barrier request waits for all outstanding writes
// R19: ordered pairs observed in program order
module cms_core_ctrl #(
    parameter int CNT_W = 4 // posted write counter width per class
) (
    input wire logic clk,
    input wire logic rst,
    // special register instructions
    input wire logic sr_valid,
    input wire logic sr_write,
    input wire logic sr_sel,
    input wire logic [31:0] sr_wdata,
    output logic [31:0] sr_rdata,
    input wire logic cps_valid,
    input wire logic cps_set,
    input wire logic isb_valid,
    // exception sequencing
    input wire logic exc_entry,
    input wire logic exc_return,
    input wire logic exc_return_thread,
    input wire logic exc_return_psp,
    input wire logic irq_cfg_pending,
    output logic exc_cfg_take,
    output logic handler_mode,
    output logic psp_active,
    output logic mask_level,
    // memory requests from the pipeline
    input wire logic mreq_valid,
    output logic mreq_ready,
    input wire logic [31:0] mreq_addr,
    input wire logic mreq_write,
    input wire logic [1:0] mreq_size,
    input wire logic [31:0] mreq_wdata,
    input wire logic mreq_fetch,
    input wire logic mreq_shareable,
    input wire logic mreq_barrier,
    output logic mresp_valid,
    output logic mresp_fault,
    output logic [31:0] mresp_rdata,
    output logic fatal_fault,
    // memory system side
    output logic bus_valid,
    output logic [31:0] bus_addr,
    output logic bus_write,
    output logic [3:0] bus_be,
    output logic [31:0] bus_wdata,
    output logic bus_bufferable,
    output logic bus_fetch,
    input wire logic bus_ack,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_wr_done,
    input wire logic [1:0] bus_wr_done_class
);
    // special register state
    logic mask; // priority mask bit
    logic spsel; // stored stack select bit
    logic next_mask;
    logic next_spsel;
    logic next_handler;
    logic next_psp;

    // decoded special register accesses
    wire msr_mask = sr_valid && sr_write && (sr_sel == `CMS_SEL_MASK);
    wire msr_ctrl = sr_valid && sr_write && (sr_sel == `CMS_SEL_CTRL);
    wire mrs_any = sr_valid && !sr_write;
    wire ret_thread = exc_return && exc_return_thread;

    // cps wins over a write in the same cycle, it is the later effect
    assign next_mask = cps_valid ? cps_set : (msr_mask ? sr_wdata[`CMS_MASK_BIT] : mask); // R2

    // entry forces main stack, return restores the thread choice
    assign next_spsel = exc_entry ? 1'b0 : // R6
                        (ret_thread ? exc_return_psp : // R6
                        ((msr_ctrl && !handler_mode) ? sr_wdata[`CMS_SPSEL_BIT] : spsel)); // R3 R4

    // handler mode for every exception; reset leaves us in thread
    assign next_handler = exc_entry ? 1'b1 : (ret_thread ? 1'b0 : handler_mode); // R9

    // the live stack only follows the bit at a barrier, entry or return
    assign next_psp = exc_entry ? 1'b0 : // R5
                      (ret_thread ? exc_return_psp :
                      ((isb_valid && !handler_mode) ? spsel : psp_active)); // R8

    // readback value, select bit hidden in handler mode
    wire [31:0] rd_mask = {31'h0, mask};
    wire [31:0] rd_ctrl = {30'h0, spsel && !handler_mode, 1'b0}; // R4
    wire [31:0] rd_value = (sr_sel == `CMS_SEL_MASK) ? rd_mask : rd_ctrl;

    // special registers and mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask <= `CMS_MASK_RST;
            spsel <= `CMS_SPSEL_RST; // R7
            handler_mode <= 1'b0;
            psp_active <= 1'b0; // R7
            mask_level <= 1'b0;
            exc_cfg_take <= 1'b0;
            sr_rdata <= 32'h0;
        end else begin
            mask <= next_mask;
            spsel <= next_spsel;
            handler_mode <= next_handler;
            psp_active <= next_psp;
            mask_level <= next_mask;
            // taken only while the mask is clear
            exc_cfg_take <= irq_cfg_pending && !mask; // R1
            if (mrs_any) begin
                sr_rdata <= rd_value;
            end
        end
    end

    // request holding register
    cms_pkg::cms_state_t state;
    logic [31:0] h_addr;
    logic h_write;
    logic [1:0] h_size;
    logic [31:0] h_wdata;
    logic h_fetch;
    logic h_share;
    logic h_barrier;

    // attributes of the held request
    cms_pkg::cms_mem_type_t h_type;
    logic h_xn;
    logic h_ppb;
    logic [3:0] h_be;
    logic [31:0] h_lanes;
    logic [31:0] h_rdata;
    logic h_misaligned;

    cms_region_decode u_decode (
        .addr(h_addr),
        .mem_type(h_type),
        .xn(h_xn),
        .private_peripheral_bus(h_ppb)
    );

    cms_lane_steer u_lanes (
        .addr_lo(h_addr[1:0]),
        .size(h_size),
        .wdata(h_wdata),
        .bus_rdata(bus_rdata),
        .be(h_be),
        .lane_wdata(h_lanes),
        .rdata(h_rdata),
        .misaligned(h_misaligned)
    );

    // faults are found before anything reaches the bus
    wire is_strong = (h_type == cms_pkg::cms_strong);
    wire is_device = (h_type == cms_pkg::cms_device);
    wire fault_xn = h_fetch && h_xn && !h_barrier; // R17
    wire fault_ppb = h_ppb && (h_size != `CMS_SIZE_WORD) && !h_barrier;
    wire fault_any = fault_xn || fault_ppb || (h_misaligned && !h_barrier);

    // strong writes are never posted, device and normal writes may be
    wire bufferable = h_write && !is_strong; // R16
    wire [1:0] h_cls = is_device ? (h_share ? `CMS_CLS_DEV_SH : `CMS_CLS_DEV_NS) : `CMS_CLS_NORMAL;

    // outstanding posted writes per class
    logic [CNT_W-1:0] cnt [3];
    logic [CNT_W-1:0] next_cnt [3];
    wire post_done = (state == cms_pkg::st_bus) && bus_ack && bus_write && bus_bufferable;
    wire all_clear = (cnt[0] == '0) && (cnt[1] == '0) && (cnt[2] == '0);
    wire dev_clear = (cnt[1] == '0) && (cnt[2] == '0);
    wire cls_full = (cnt[h_cls] == {CNT_W{1'b1}}); // a full counter stalls, never wraps

    // ordering gate; device waits only on device, which keeps the pairs in order
    wire order_ok = (h_barrier || is_strong) ? all_clear : // R15 R18 R19
                    (is_device ? (dev_clear && !cls_full) : !cls_full); // R13 R14 R19

    // counters: post increments at acceptance, memory reports retirement
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_cnt[i] = cnt[i];
            if (post_done && (h_cls == 2'(i))) begin
                next_cnt[i] = next_cnt[i] + CNT_W'(1);
            end
            if (bus_wr_done && (bus_wr_done_class == 2'(i))) begin
                next_cnt[i] = next_cnt[i] - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                cnt[i] <= next_cnt[i];
            end
        end
    end

    // capture a request while idle
    wire take_req = (state == cms_pkg::st_idle) && mreq_valid && mreq_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            h_addr <= 32'h0;
            h_write <= 1'b0;
            h_size <= 2'h0;
            h_wdata <= 32'h0;
            h_fetch <= 1'b0;
            h_share <= 1'b0;
            h_barrier <= 1'b0;
        end else if (take_req) begin
            h_addr <= mreq_addr;
            h_write <= mreq_write && !mreq_fetch;
            h_size <= mreq_size;
            h_wdata <= mreq_wdata;
            h_fetch <= mreq_fetch;
            h_share <= mreq_shareable;
            h_barrier <= mreq_barrier;
        end
    end

    // access sequencer: one request in flight, bus held until acknowledged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= cms_pkg::st_idle;
            mreq_ready <= 1'b1;
            mresp_valid <= 1'b0;
            mresp_fault <= 1'b0;
            mresp_rdata <= 32'h0;
            fatal_fault <= 1'b0;
            bus_valid <= 1'b0;
            bus_addr <= 32'h0;
            bus_write <= 1'b0;
            bus_be <= 4'h0;
            bus_wdata <= 32'h0;
            bus_bufferable <= 1'b0;
            bus_fetch <= 1'b0;
        end else begin
            mresp_valid <= 1'b0;
            mresp_fault <= 1'b0;
            fatal_fault <= 1'b0;
            case (state)
                cms_pkg::st_idle: begin
                    // not ready from each accept until its response is given
                    if (take_req) begin
                        mreq_ready <= 1'b0;
                        state <= cms_pkg::st_order;
                    end
                end
                cms_pkg::st_order: begin
                    if (fault_any) begin
                        // answered at once with a fault, nothing issued
                        mresp_valid <= 1'b1;
                        mresp_fault <= 1'b1;
                        fatal_fault <= fault_xn; // R17
                        mreq_ready <= 1'b1;
                        state <= cms_pkg::st_idle;
                    end else if (order_ok && h_barrier) begin
                        // barrier completes once everything has drained
                        mresp_valid <= 1'b1; // R18
                        mreq_ready <= 1'b1;
                        state <= cms_pkg::st_idle;
                    end else if (order_ok) begin
                        bus_valid <= 1'b1;
                        bus_addr <= h_addr;
                        bus_write <= h_write;
                        bus_be <= h_be; // R10 R11
                        bus_wdata <= h_lanes; // R11
                        bus_bufferable <= bufferable; // R16
                        bus_fetch <= h_fetch;
                        state <= cms_pkg::st_bus;
                    end
                end
                cms_pkg::st_bus: begin
                    if (bus_ack) begin
                        bus_valid <= 1'b0;
                        mresp_valid <= 1'b1;
                        mresp_rdata <= h_write ? 32'h0 : h_rdata; // R11
                        mreq_ready <= 1'b1;
                        state <= cms_pkg::st_idle;
                    end
                end
                default: begin
                    state <= cms_pkg::st_idle;
                    mreq_ready <= 1'b1;
                    bus_valid <= 1'b0;
                end
            endcase
        end
    end

    // checks next to the logic they guard
    a_mask_blocks_take: assert property (@(posedge clk) disable iff (rst) // R1
        mask |=> !exc_cfg_take) else $error("exception taken while masked");

    a_cps_sets_mask: assert property (@(posedge clk) disable iff (rst) // R2
        cps_valid |=> (mask_level == $past(cps_set))) else $error("cps did not set mask");

    a_handler_read_zero: assert property (@(posedge clk) disable iff (rst) // R4
        (mrs_any && sr_sel == `CMS_SEL_CTRL && handler_mode) |=> (sr_rdata == 32'h0))
        else $error("select bit visible in handler mode");

    a_handler_main_stack: assert property (@(posedge clk) disable iff (rst) // R5
        handler_mode |-> !psp_active) else $error("process stack used in handler mode");

    a_entry_clears_sel: assert property (@(posedge clk) disable iff (rst) // R6
        exc_entry |=> (handler_mode && !spsel && !psp_active)) else $error("entry did not reset stack");

    a_isb_applies_sel: assert property (@(posedge clk) disable iff (rst) // R8
        (isb_valid && !handler_mode && !exc_entry && !exc_return) |=> (psp_active == $past(spsel)))
        else $error("barrier did not apply stack select");

    a_xn_fetch_fault: assert property (@(posedge clk) disable iff (rst) // R17
        (state == cms_pkg::st_order && fault_xn) |=> (fatal_fault && mresp_fault && !bus_valid))
        else $error("execute never fetch not faulted");

    a_strong_unposted: assert property (@(posedge clk) disable iff (rst) // R16
        (bus_valid && is_strong) |-> !bus_bufferable) else $error("strong write posted");

    a_strong_drained: assert property (@(posedge clk) disable iff (rst) // R15
        $rose(bus_valid) && is_strong |-> $past(all_clear)) else $error("strong access overtook writes");

    a_word_lanes: assert property (@(posedge clk) disable iff (rst) // R10
        (bus_valid && h_size == `CMS_SIZE_WORD) |-> (bus_be == 4'hf)) else $error("word lanes wrong");
endmodule

// *** test/cms_mem_model.sv ***
`timescale 1ns/100ps
// memory system stand-in: word store, wait states, posted write retire
module cms_mem_model #(
    parameter int RET_DLY = 20 // age at which a posted write retires
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic shr,
    input wire logic bus_valid,
    input wire logic [31:0] bus_addr,
    input wire logic bus_write,
    input wire logic [3:0] bus_be,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_bufferable,
    output logic bus_ack,
    output logic [31:0] bus_rdata,
    output logic bus_wr_done,
    output logic [1:0] bus_wr_done_class
);
    logic [31:0] mem [16]; // tiny store indexed by word address
    logic [1:0] q[$]; // classes of writes still buffered
    logic acked; // answered, bus_valid not yet dropped
    int wait_c; // wait states spent on this access
    int ret_c; // age of oldest buffered write
    wire [3:0] nib = bus_addr[31:28];
    wire dev = nib inside {4'h4, 4'h5, [4'ha:4'hd]} || (nib == 4'he && bus_addr[27:20] != 8'h00);
    // one access at a time; read data toggles except in the cycle a read is answered
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_ack <= 1'b0;
            bus_rdata <= 32'h0;
            bus_wr_done <= 1'b0;
            bus_wr_done_class <= 2'h0;
            acked <= 1'b0;
            wait_c <= 0;
            ret_c <= 0;
        end else begin
            bus_ack <= 1'b0;
            bus_wr_done <= 1'b0;
            bus_rdata <= ~bus_rdata; // stale data must never look valid
            if (!bus_valid) begin
                acked <= 1'b0;
                wait_c <= 0;
            end else if (!acked && wait_c < (slow ? 3 : 0)) begin
                wait_c <= wait_c + 1;
            end else if (!acked) begin
                bus_ack <= 1'b1;
                acked <= 1'b1;
                if (!bus_write) begin
                    bus_rdata <= mem[bus_addr[5:2]];
                end
                for (int i = 0; i < 4; i++) begin
                    if (bus_write && bus_be[i]) begin
                        mem[bus_addr[5:2]][8*i +: 8] <= bus_wdata[8*i +: 8];
                    end
                end
                if (bus_write && bus_bufferable) begin
                    q.push_back(dev ? (shr ? 2'h2 : 2'h1) : 2'h0);
                end
            end
            // oldest buffered write retires after a fixed age
            if (q.size() == 0) begin
                ret_c <= 0;
            end else if (ret_c == RET_DLY) begin
                bus_wr_done <= 1'b1;
                bus_wr_done_class <= q.pop_front();
                ret_c <= 0;
            end else begin
                ret_c <= ret_c + 1;
            end
        end
    end
endmodule

// *** test/cms_core_ctrl_tb.sv ***
`timescale 1ns/100ps
`include "cms_regs.svh"
// self-checking bench: mask, stack select, lanes, faults, ordering
module cms_core_ctrl_tb;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic sr_valid = 1'b0, sr_write = 1'b0, sr_sel = 1'b0, cps_valid = 1'b0, cps_set = 1'b0, isb_valid = 1'b0;
    logic exc_entry = 1'b0, exc_return = 1'b0, exc_return_thread = 1'b0, exc_return_psp = 1'b0;
    logic irq_cfg_pending = 1'b0, mreq_valid = 1'b0, mreq_write = 1'b0, mreq_fetch = 1'b0;
    logic mreq_shareable = 1'b0, mreq_barrier = 1'b0;
    logic [31:0] sr_wdata = 32'h0, mreq_addr = 32'h0, mreq_wdata = 32'h44332211;
    logic [1:0] mreq_size = 2'h0;
    logic [31:0] sr_rdata, mresp_rdata, bus_addr, bus_wdata, bus_rdata;
    logic exc_cfg_take, handler_mode, psp_active, mask_level, mreq_ready, mresp_valid, mresp_fault;
    logic fatal_fault, bus_valid, bus_write, bus_bufferable, bus_fetch, bus_ack, bus_wr_done;
    logic [1:0] bus_wr_done_class;
    logic [3:0] bus_be;
    int n_mismatch = 0, n_compared = 0, cyc = 0, t_done = 0, t_bus = 0;
    logic bv_q = 1'b0; // bus_valid one cycle ago
    logic [31:0] m_rd; // last response data
    logic m_flt, m_bf, m_ff, m_fe; // fault, bufferable, fatal, fetch seen
    logic [3:0] m_be; // lanes seen on the bus, 0 if none

    // small counters keep the test short
    cms_core_ctrl #(.CNT_W(2)) dut (.clk, .rst, .sr_valid, .sr_write, .sr_sel, .sr_wdata, .sr_rdata,
        .cps_valid, .cps_set, .isb_valid, .exc_entry, .exc_return, .exc_return_thread, .exc_return_psp,
        .irq_cfg_pending, .exc_cfg_take, .handler_mode, .psp_active, .mask_level, .mreq_valid,
        .mreq_ready, .mreq_addr, .mreq_write, .mreq_size, .mreq_wdata, .mreq_fetch, .mreq_shareable,
        .mreq_barrier, .mresp_valid, .mresp_fault, .mresp_rdata, .fatal_fault, .bus_valid, .bus_addr,
        .bus_write, .bus_be, .bus_wdata, .bus_bufferable, .bus_fetch, .bus_ack, .bus_rdata,
        .bus_wr_done, .bus_wr_done_class);
    cms_mem_model #(.RET_DLY(20)) mem_i (.clk, .rst, .slow, .shr(mreq_shareable), .bus_valid, .bus_addr,
        .bus_write, .bus_be, .bus_wdata, .bus_bufferable, .bus_ack, .bus_rdata, .bus_wr_done,
        .bus_wr_done_class);

    always #50 clk = ~clk;

    // cycle count, hang limit, bus start and retire times
    always @(negedge clk) begin
        cyc <= cyc + 1;
        bv_q <= bus_valid;
        if (bus_wr_done === 1'b1) t_done <= cyc;
        if (bus_valid === 1'b1 && bv_q !== 1'b1) t_bus <= cyc;
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one special register instruction, returns when the answer stands
    task automatic sr(input logic w, input logic sel, input logic [31:0] d);
        @(posedge clk);
        sr_valid <= 1'b1;
        sr_write <= w;
        sr_sel <= sel;
        sr_wdata <= d;
        @(posedge clk);
        sr_valid <= 1'b0;
        @(negedge clk);
    endtask

    // event pulse: 0 cps, 1 sync barrier, 2 entry, 3 return
    task automatic ev(input int k);
        @(posedge clk);
        cps_valid <= (k == 0);
        isb_valid <= (k == 1);
        exc_entry <= (k == 2);
        exc_return <= (k == 3);
        @(posedge clk);
        {cps_valid, isb_valid, exc_entry, exc_return} <= 4'h0;
        @(negedge clk);
    endtask

    // one memory request, issued for one cycle once ready, waits for the response
    task automatic mem(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic f, input logic s);
        int n;
        for (n = 0; n < 60 && mreq_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        mreq_valid <= 1'b1;
        mreq_addr <= a;
        mreq_write <= w;
        mreq_size <= sz;
        mreq_fetch <= f;
        mreq_shareable <= s;
        @(posedge clk);
        mreq_valid <= 1'b0;
        {m_ff, m_be, m_bf, m_fe} = 7'h0;
        for (n = 0; n < 60; n++) begin
            @(negedge clk);
            if (bus_valid === 1'b1) {m_be, m_bf, m_fe} = {bus_be, bus_bufferable, bus_fetch};
            m_ff = m_ff | fatal_fault;
            if (mresp_valid === 1'b1) break;
        end
        chk(mresp_valid, 1'b1);
        m_rd = mresp_rdata;
        m_flt = mresp_fault;
    endtask

    task automatic t_mask();
        irq_cfg_pending <= 1'b1;
        sr(1'b1, `CMS_SEL_MASK, 32'h1);
        chk(mask_level, 1'b1);
        @(negedge clk);
        chk(exc_cfg_take, 1'b0);
        sr(1'b0, `CMS_SEL_MASK, 32'h0);
        chk(sr_rdata, 32'h1);
        cps_set <= 1'b0;
        ev(0);
        chk(mask_level, 1'b0);
        @(negedge clk);
        chk(exc_cfg_take, 1'b1);
        cps_set <= 1'b1;
        ev(0);
        @(negedge clk);
        chk(exc_cfg_take, 1'b0);
        sr(1'b1, `CMS_SEL_MASK, 32'hfffffffe);
        chk(mask_level, 1'b0);
        irq_cfg_pending <= 1'b0;
    endtask

    task automatic t_stack();
        sr(1'b0, `CMS_SEL_CTRL, 32'h0);
        chk(sr_rdata, 32'h0);
        sr(1'b1, `CMS_SEL_CTRL, 32'h2);
        chk(psp_active, 1'b0);
        ev(1);
        chk(psp_active, 1'b1);
        sr(1'b0, `CMS_SEL_CTRL, 32'h0);
        chk(sr_rdata, 32'h2);
        sr(1'b1, `CMS_SEL_CTRL, 32'hfffffffd);
        ev(1);
        sr(1'b0, `CMS_SEL_CTRL, 32'h0);
        chk(sr_rdata, 32'h0);
        sr(1'b1, `CMS_SEL_CTRL, 32'h2);
        ev(1);
        ev(2);
        chk(handler_mode, 1'b1);
        chk(psp_active, 1'b0);
        sr(1'b0, `CMS_SEL_CTRL, 32'h0);
        chk(sr_rdata, 32'h0);
        sr(1'b1, `CMS_SEL_CTRL, 32'h2);
        ev(1);
        chk(psp_active, 1'b0);
        exc_return_thread <= 1'b1;
        exc_return_psp <= 1'b1;
        ev(3);
        chk(handler_mode, 1'b0);
        sr(1'b0, `CMS_SEL_CTRL, 32'h0);
        chk(sr_rdata, 32'h2);
        chk(psp_active, 1'b1);
        ev(2);
        exc_return_psp <= 1'b0;
        ev(3);
        @(negedge clk);
        chk(psp_active, 1'b0);
    endtask

    task automatic t_lanes();
        mem(32'h20000010, 1'b1, `CMS_SIZE_WORD, 1'b0, 1'b0);
        chk(m_be, 4'hf);
        mem(32'h20000013, 1'b0, `CMS_SIZE_BYTE, 1'b0, 1'b0);
        chk(m_be, 4'h8);
        chk(m_rd, 32'h44);
        mem(32'h20000012, 1'b0, `CMS_SIZE_HALF, 1'b0, 1'b0);
        chk(m_be, 4'hc);
        chk(m_rd, 32'h4433);
        mem(32'h20000010, 1'b0, `CMS_SIZE_WORD, 1'b1, 1'b0);
        chk(m_rd, 32'h44332211);
        chk(m_ff, 1'b0);
        chk(m_fe, 1'b1);
        // narrow write lands on its own lane only
        mem(32'h20000011, 1'b1, `CMS_SIZE_BYTE, 1'b0, 1'b0);
        chk(m_be, 4'h2);
        mem(32'h20000010, 1'b0, `CMS_SIZE_WORD, 1'b0, 1'b0);
        chk(m_rd, 32'h44331111);
        chk(m_fe, 1'b0);
    endtask

    // execute-never fetch, non-word private bus, misaligned, bad size
    task automatic t_faults();
        logic [31:0] fa [4] = '{32'h40000000, 32'he000e010, 32'h20000011, 32'h20000010};
        logic [1:0] fs [4] = '{`CMS_SIZE_WORD, `CMS_SIZE_BYTE, `CMS_SIZE_HALF, 2'h3};
        for (int i = 0; i < 4; i++) begin
            mem(fa[i], 1'b0, fs[i], i == 0, 1'b0);
            chk(m_flt, 1'b1);
            chk(m_be, 4'h0);
            chk(m_ff, i == 0);
        end
    endtask

    // posted device write, then an access that must wait for its retire
    task automatic t_order(input logic [31:0] a2, input logic w2, input logic s);
        int t0;
        repeat (30) @(negedge clk);
        t0 = cyc;
        mem(32'h40000020, 1'b1, `CMS_SIZE_WORD, 1'b0, s);
        chk(m_bf, 1'b1);
        mem(a2, w2, `CMS_SIZE_WORD, 1'b0, s);
        chk(t_done > t0, 1'b1);
        chk(t_bus > t_done, 1'b1);
        if (w2) chk(m_bf, 1'b0);
    endtask

    // normal read passes a posted device write, a barrier waits for it
    task automatic t_barrier();
        int t0;
        repeat (30) @(negedge clk);
        t0 = cyc;
        mem(32'h40000028, 1'b1, `CMS_SIZE_WORD, 1'b0, 1'b0);
        mem(32'h20000010, 1'b0, `CMS_SIZE_WORD, 1'b0, 1'b0);
        chk(t_done < t0, 1'b1);
        @(posedge clk);
        mreq_barrier <= 1'b1;
        mem(32'h0, 1'b0, `CMS_SIZE_WORD, 1'b0, 1'b0);
        mreq_barrier <= 1'b0;
        chk(t_done > t0, 1'b1);
        chk({m_flt, m_be}, 5'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_mask();
        t_stack();
        t_lanes();
        t_faults();
        slow <= 1'b1;
        t_order(32'he000e010, 1'b1, 1'b0);
        t_order(32'h40000024, 1'b0, 1'b1);
        t_barrier();
        summarize();
    end
endmodule
